// >>> core/dac_ctrl_pkg.sv
// Constants for the DAC reset and gain command block
package dac_ctrl_pkg;
    localparam int          WORD_BITS      = 24;
    localparam int          CODE_BITS      = 16;
    localparam int          CHANNELS       = 8;
    localparam int          CMD_MSB        = 23;
    localparam int          CMD_LSB        = 20;
    localparam int          ADDR_MSB       = 19;
    localparam int          ADDR_LSB       = 16;
    localparam int          DATA_MSB       = 15;
    localparam int          DATA_LSB       = 0;
    localparam int          GAIN_POS       = 2;
    localparam logic [3:0]  CMD_WRITE_IN   = 4'h1;
    localparam logic [3:0]  CMD_UPDATE     = 4'h2;
    localparam logic [3:0]  CMD_WRITE_UPD  = 4'h3;
    localparam logic [3:0]  CMD_SOFT_RESET = 4'h6;
    localparam logic [3:0]  CMD_GAIN_SETUP = 4'h7;
    localparam logic [3:0]  RESET_ADDR_KEY = 4'h0;
    localparam logic [15:0] RESET_DATA_KEY = 16'h1234;
    localparam logic [15:0] ZERO_SCALE     = 16'h0000;
    localparam logic [15:0] MID_SCALE      = 16'h8000;
    localparam logic        GAIN_RESET     = 1'b0;
    localparam logic [1:0]  GAIN_RSVD_ZERO = 2'h0;
endpackage : dac_ctrl_pkg

// >>> core/dac_reset_gain_control.sv
// Reset select, software reset and gain setup command handling
`timescale 1ns/100ps
module dac_reset_gain_control #(
    parameter int  CHANNELS   = 8,
    parameter bit  HAS_SELECT = 1'b1
) (
    input  wire logic                core_clk_in,
    input  wire logic                rst_in,
    input  wire logic                sclk_in,
    input  wire logic                sdin_in,
    input  wire logic                sync_n_in,
    input  wire logic                power_up_level_select_in,
    output logic [CHANNELS*16-1:0]   channel_output_out,
    output logic                     gain_two_out,
    output logic                     written_out
);
    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b00,
        ST_RESET   = 2'b01,
        ST_RUN     = 2'b11
    } state_type;

    state_type    state_ff;
    logic [1:0]   sel_sync_ff;
    logic [15:0]  reset_code_ff;
    logic [23:0]  word;
    logic         word_valid;
    logic [3:0]   cmd;
    logic [3:0]   addr;
    logic [15:0]  data;
    logic [15:0]  input_reg_ff [CHANNELS];
    logic         soft_reset;

    function automatic logic addr_hits(input logic [3:0] a, input int ch);
        addr_hits = (a == ch[3:0]);
    endfunction : addr_hits

    serial_word_rx u_rx (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .sclk_in        (sclk_in),
        .sdin_in        (sdin_in),
        .sync_n_in      (sync_n_in),
        .word_out       (word),
        .word_valid_out (word_valid)
    );

    assign cmd  = word[dac_ctrl_pkg::CMD_MSB:dac_ctrl_pkg::CMD_LSB];
    assign addr = word[dac_ctrl_pkg::ADDR_MSB:dac_ctrl_pkg::ADDR_LSB];
    assign data = word[dac_ctrl_pkg::DATA_MSB:dac_ctrl_pkg::DATA_LSB];

    // Keyed reset only; other keys ignored
    assign soft_reset = word_valid && (cmd == dac_ctrl_pkg::CMD_SOFT_RESET)
                        && (addr == dac_ctrl_pkg::RESET_ADDR_KEY)
                        && (data == dac_ctrl_pkg::RESET_DATA_KEY);

    // ==========================================================
    // Select pin synchroniser
    // Free-running so the pin has settled by the time reset is released
    always_ff @(posedge core_clk_in) begin
        sel_sync_ff <= {sel_sync_ff[0], power_up_level_select_in};
    end

    // ==========================================================
    // Power-on sequence: capture select, then load reset code
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_ff      <= ST_CAPTURE;
            reset_code_ff <= dac_ctrl_pkg::ZERO_SCALE;
        end else begin
            case (state_ff)
                ST_CAPTURE: begin
                    if (HAS_SELECT && sel_sync_ff[1]) begin
                        reset_code_ff <= dac_ctrl_pkg::MID_SCALE;
                    end else begin
                        reset_code_ff <= dac_ctrl_pkg::ZERO_SCALE;
                    end
                    state_ff <= ST_RESET;
                end
                ST_RESET: begin
                    state_ff <= ST_RUN;
                end
                default: begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    // ==========================================================
    // Channel registers and outputs
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    input_reg_ff[ch]                    <= dac_ctrl_pkg::ZERO_SCALE;
                    channel_output_out[ch*16 +: 16]     <= dac_ctrl_pkg::ZERO_SCALE;
                end else if (state_ff == ST_RESET || soft_reset) begin
                    input_reg_ff[ch]                    <= reset_code_ff;
                    channel_output_out[ch*16 +: 16]     <= reset_code_ff;
                end else if (state_ff == ST_RUN && word_valid
                             && addr_hits(addr, ch)) begin
                    if (cmd == dac_ctrl_pkg::CMD_WRITE_IN) begin
                        input_reg_ff[ch] <= data;
                    end else if (cmd == dac_ctrl_pkg::CMD_UPDATE) begin
                        channel_output_out[ch*16 +: 16] <= input_reg_ff[ch];
                    end else if (cmd == dac_ctrl_pkg::CMD_WRITE_UPD) begin
                        input_reg_ff[ch]                <= data;
                        channel_output_out[ch*16 +: 16] <= data;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Gain setup register
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            gain_two_out <= dac_ctrl_pkg::GAIN_RESET;
        end else if (state_ff == ST_RESET || soft_reset) begin
            gain_two_out <= dac_ctrl_pkg::GAIN_RESET;
        end else if (word_valid && cmd == dac_ctrl_pkg::CMD_GAIN_SETUP) begin
            gain_two_out <= word[dac_ctrl_pkg::GAIN_POS];
        end
    end

    // Marks that an update or write-and-update command, to any address, has arrived since the last reset or soft reset
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            written_out <= 1'b0;
        end else if (state_ff == ST_RESET || soft_reset) begin
            written_out <= 1'b0;
        end else if (word_valid && (cmd == dac_ctrl_pkg::CMD_WRITE_UPD
                     || cmd == dac_ctrl_pkg::CMD_UPDATE)) begin
            written_out <= 1'b1;
        end
    end
endmodule : dac_reset_gain_control

// >>> core/serial_word_rx.sv
// Serial receiver: samples link pins, assembles 24-bit words
`timescale 1ns/100ps
module serial_word_rx (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        sclk_in,
    input  wire logic        sdin_in,
    input  wire logic        sync_n_in,
    output logic [23:0]      word_out,
    output logic             word_valid_out
);
    logic [1:0]  sclk_sync_ff;
    logic [1:0]  sdin_sync_ff;
    logic [1:0]  sync_sync_ff;
    logic        sclk_prev_ff;
    logic        sync_prev_ff;
    logic [23:0] shift_ff;
    logic [4:0]  count_ff;
    logic        sclk_fall;
    logic        sync_rise;

    // ==========================================================
    // Two-stage synchronisers
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sclk_sync_ff <= 2'h0;
            sdin_sync_ff <= 2'h0;
            sync_sync_ff <= 2'h3;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], sclk_in};
            sdin_sync_ff <= {sdin_sync_ff[0], sdin_in};
            sync_sync_ff <= {sync_sync_ff[0], sync_n_in};
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sclk_prev_ff <= 1'b0;
            sync_prev_ff <= 1'b1;
        end else begin
            sclk_prev_ff <= sclk_sync_ff[1];
            sync_prev_ff <= sync_sync_ff[1];
        end
    end

    assign sclk_fall = sclk_prev_ff && !sclk_sync_ff[1];
    assign sync_rise = !sync_prev_ff && sync_sync_ff[1];

    // ==========================================================
    // Shift on falling serial clock while frame is open
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            shift_ff <= 24'h000000;
            count_ff <= 5'h00;
        end else if (sync_sync_ff[1]) begin
            count_ff <= 5'h00;
        end else if (sclk_fall) begin
            shift_ff <= {shift_ff[22:0], sdin_sync_ff[1]};
            // Saturate above 24 so that long frames are refused too
            if (count_ff != 5'h1F) begin
                count_ff <= count_ff + 5'h01;
            end
        end
    end

    // Word valid only with exactly 24 bits at sync rise
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            word_out       <= 24'h000000;
            word_valid_out <= 1'b0;
        end else begin
            word_valid_out <= sync_rise && (count_ff == 5'h18);
            if (sync_rise) begin
                word_out <= shift_ff;
            end
        end
    end
endmodule : serial_word_rx

// >>> test/dac_reset_gain_control_sva.sv
// Checker on the reset and gain command block ports
`timescale 1ns/100ps
module dac_reset_gain_control_sva #(
    parameter int CHANNELS   = 8,
    parameter bit HAS_SELECT = 1'b1
) (
    input wire logic                   core_clk_in,
    input wire logic                   rst_in,
    input wire logic                   sclk_in,
    input wire logic                   sdin_in,
    input wire logic                   sync_n_in,
    input wire logic                   power_up_level_select_in,
    input wire logic [CHANNELS*16-1:0] channel_output_out,
    input wire logic                   gain_two_out,
    input wire logic                   written_out
);
    logic [2:0]  s_ff, y_ff;
    logic [23:0] sh_ff;
    logic [5:0]  n_ff;
    logic [3:0]  q_ff;
    logic        done, bad, rst_cmd, key;
    logic [15:0] pu;
    assign pu = (HAS_SELECT && power_up_level_select_in) ? dac_ctrl_pkg::MID_SCALE
                                                          : dac_ctrl_pkg::ZERO_SCALE;
    assign done    = ~y_ff[2] & y_ff[1] & (n_ff == 6'h18);
    assign bad     = ~y_ff[2] & y_ff[1] & (n_ff != 6'h18);
    assign rst_cmd = done && sh_ff[23:20] == dac_ctrl_pkg::CMD_SOFT_RESET;
    assign key     = sh_ff[19:0] == 20'h01234;
    always_ff @(posedge core_clk_in) begin
        s_ff <= {s_ff[1:0], sclk_in};
        y_ff <= {y_ff[1:0], sync_n_in};
    end
    // Own copy of the shifted frame
    always_ff @(posedge core_clk_in) begin
        if (y_ff[1]) begin
            n_ff <= 6'h00;
        end else if (s_ff[2] & ~s_ff[1]) begin
            n_ff  <= n_ff + 6'h01;
            sh_ff <= {sh_ff[22:0], sdin_in};
        end
    end
    // Cycles since reset or frame end
    always_ff @(posedge core_clk_in) begin
        if (rst_in || (~y_ff[2] & y_ff[1])) q_ff <= 4'h0;
        else if (q_ff != 4'hF) q_ff <= q_ff + 4'h1;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    reset_clear_a: assert property (disable iff (1'b0) rst_in |=>
        channel_output_out == '0 && !gain_two_out && !written_out) else $error("reset clear");
    powerup_code_a: assert property ($fell(rst_in) |-> ##[1:3]
        channel_output_out == {CHANNELS{pu}}) else $error("power-up code");
    quiet_chan_a: assert property (q_ff == 4'hF |-> $stable(channel_output_out))
        else $error("output moved without frame");
    quiet_gain_a: assert property (q_ff == 4'hF |-> $stable(gain_two_out))
        else $error("gain moved without frame");
    soft_reset_a: assert property (rst_cmd && key |-> ##[3:10]
        channel_output_out == {CHANNELS{pu}} && !gain_two_out) else $error("soft reset");
    bad_key_a: assert property (rst_cmd && !key |=>
        ($stable(channel_output_out) && $stable(gain_two_out)) [*8]) else $error("bad key");
    gain_set_a: assert property (done && sh_ff[23:20] == dac_ctrl_pkg::CMD_GAIN_SETUP
        |-> ##[3:10] gain_two_out == sh_ff[2]) else $error("gain setup");
    short_frame_a: assert property (bad |=> $stable(channel_output_out) [*8])
        else $error("short frame acted on");
    cover property (rst_cmd && key);
    cover property (rst_cmd && !key);
    cover property (done && sh_ff[23:20] == dac_ctrl_pkg::CMD_GAIN_SETUP);
endmodule : dac_reset_gain_control_sva
bind dac_reset_gain_control dac_reset_gain_control_sva #(.CHANNELS(CHANNELS),
    .HAS_SELECT(HAS_SELECT)) u_sva (.*);

// >>> test/spi_host_model.sv
// Host serial master model sending command frames
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic core_clk_in,
    output logic      sclk_out,
    output logic      sdin_out,
    output logic      sync_n_out
);
    initial begin
        sclk_out   = 1'b1;
        sdin_out   = 1'b0;
        sync_n_out = 1'b1;
    end
    // Top n bits, MSB first, 125 ns per bit
    task automatic send(input logic [23:0] word, input int n);
        @(negedge core_clk_in);
        sync_n_out = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            sdin_out = word[i];
            repeat (12) @(negedge core_clk_in);
            sclk_out = 1'b0;
            repeat (13) @(negedge core_clk_in);
            sclk_out = 1'b1;
        end
        sync_n_out = 1'b1;
        sdin_out   = ~sdin_out;
        repeat (20) @(negedge core_clk_in);
    endtask : send
endmodule : spi_host_model

// >>> test/tb_dac_reset_gain_control.sv
// Self-checking bench for reset and gain command handling
`timescale 1ns/100ps
module tb_dac_reset_gain_control;
    logic         core_clk_in, rst_in, sel, sclk, sdin, sync_n, gain, gain_v, wr;
    logic [127:0] chan, chan_v;
    logic [23:0]  gw[3] = '{24'h7FFFFC, 24'h7FFFF8, 24'h700004};
    logic [23:0]  bk[3] = '{24'h611234, 24'h601235, 24'h601234};
    logic [127:0] ch2 = {80'h0, 16'hABCD, 32'h0};
    int           mismatches, num_checks, cyc;
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    spi_host_model u_host (.core_clk_in(core_clk_in), .sclk_out(sclk), .sdin_out(sdin),
        .sync_n_out(sync_n));
    dac_reset_gain_control u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk),
        .sdin_in(sdin), .sync_n_in(sync_n), .power_up_level_select_in(sel),
        .channel_output_out(chan), .gain_two_out(gain), .written_out(wr));
    dac_reset_gain_control #(.HAS_SELECT(1'b0)) u_var (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .sclk_in(sclk), .sdin_in(sdin), .sync_n_in(sync_n),
        .power_up_level_select_in(sel), .channel_output_out(chan_v),
        .gain_two_out(gain_v), .written_out());
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic do_reset(input logic s);
        @(negedge core_clk_in);
        rst_in = 1'b1;
        sel    = s;
        repeat (10) @(negedge core_clk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge core_clk_in);
    endtask : do_reset
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        rst_in = 1'b1;
        sel    = 1'b0;
        do_reset(1'b0);
        chk("zero power-up", 128'h0, chan);
        chk("variant power-up", 128'h0, chan_v);
        chk("gain default", 128'h0, gain);
        foreach (gw[i]) begin
            u_host.send(gw[i], 24);
            chk("gain", gw[i][2], gain);
            chk("variant gain", gw[i][2], gain_v);
        end
        chk("held level", 128'h0, chan);
        chk("not written", 128'h0, wr);
        u_host.send(24'h32ABCD, 24);
        chk("channel write", ch2, chan);
        chk("written", 128'h1, wr);
        foreach (bk[i]) begin
            u_host.send(bk[i], (i == 2) ? 23 : 24);
            chk("refused frame", ch2, chan);
            chk("gain kept", 128'h1, gain);
        end
        u_host.send(24'h601234, 24);
        chk("soft reset", 128'h0, chan);
        chk("gain after reset", 128'h0, gain);
        chk("written cleared", 128'h0, wr);
        $display("test zero-scale commands done");
        do_reset(1'b1);
        chk("mid power-up", {8{16'h8000}}, chan);
        chk("variant power-up", 128'h0, chan_v);
        u_host.send(24'h300001, 24);
        chk("channel write", {{7{16'h8000}}, 16'h0001}, chan);
        u_host.send(24'h601234, 24);
        chk("soft reset mid", {8{16'h8000}}, chan);
        $display("test midscale commands done");
        results();
    end
endmodule : tb_dac_reset_gain_control
